/* File: hdl/gpio_map.vh */
`ifndef GPIO_MAP_VH
`define GPIO_MAP_VH

// Register byte offsets; each register is one word holding one 8-bit port.
`define OFS_DATA 12'h000
`define OFS_DIR 12'h010
`define OFS_PULL 12'h100
`define OFS_SLEW 12'h110
`define OFS_DRIVE 12'h120

// Decoded register groups.
`define GRP_DATA 3'h0
`define GRP_DIR 3'h1
`define GRP_PULL 3'h2
`define GRP_SLEW 3'h3
`define GRP_DRIVE 3'h4
`define GRP_NONE 3'h7

// Reset values per port byte.
`define RST_DATA 8'h00
`define RST_DIR 8'h00
`define RST_PULL 8'h00
`define RST_SLEW 8'hFF
`define RST_DRIVE 8'h00

// Oscillator pins inside port G and the index of port F, one below port G.
`define OSC_MASK 8'h60
`define PORT_G_IDX 2

// Bus responses.
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

/* File: hdl/gpio_ports.v */
`timescale 1ns/100ps
`include "gpio_map.vh"

module gpio_ports (
	// Clock and reset.
	input wire SYS_CLK_I,
	input wire ARST_N_I,
	// AXI4-Lite write address channel.
	input wire [11:0] AWADDR_I,
	input wire AWVALID_I,
	output wire AWREADY_O,
	// AXI4-Lite write data channel.
	input wire [31:0] WDATA_I,
	input wire [3:0] WSTRB_I,
	input wire WVALID_I,
	output wire WREADY_O,
	// AXI4-Lite write response channel.
	output wire [1:0] BRESP_O,
	output wire BVALID_O,
	input wire BREADY_I,
	// AXI4-Lite read address channel.
	input wire [11:0] ARADDR_I,
	input wire ARVALID_I,
	output wire ARREADY_O,
	// AXI4-Lite read data channel.
	output wire [31:0] RDATA_O,
	output wire [1:0] RRESP_O,
	output wire RVALID_O,
	input wire RREADY_I,
	// Pads, ports D, E, F, G at bytes 0 to 3.
	input wire [31:0] PIN_I,
	output wire [31:0] PIN_O,
	output wire [31:0] PIN_OE_N_O,
	output wire [31:0] PIN_PULLUP_O,
	output wire [31:0] PIN_SLEW_O,
	output wire [31:0] PIN_HIDRIVE_O,
	// Shared digital peripherals.
	input wire [31:0] PERIPH_EN_I,
	input wire [31:0] PERIPH_DIR_I,
	input wire [31:0] PERIPH_OUT_I,
	input wire [31:0] KEYPAD_EN_I,
	output wire [31:0] PIN_SYNC_O,
	// Analog converter inputs and oscillator.
	input wire [31:0] ANALOG_EN_I,
	input wire OSC_EN_I
);

	// Register storage, one byte per port.
	reg [31:0] data_reg;
	reg [31:0] dir_reg;
	reg [31:0] pull_reg;
	reg [31:0] slew_reg;
	reg [31:0] drive_reg;

	// Write channel state.
	reg aw_full_reg;
	reg [11:0] aw_addr_reg;
	reg w_full_reg;
	reg [7:0] w_data_reg;
	reg w_strb_reg;
	reg bvalid_reg;
	reg [1:0] bresp_reg;

	// Read channel state.
	reg rvalid_reg;
	reg [31:0] rdata_reg;
	reg [1:0] rresp_reg;

	wire aw_take;
	wire w_take;
	wire do_write;
	wire ar_take;
	wire [2:0] wr_grp;
	wire [1:0] wr_port;
	wire [2:0] rd_grp;
	wire [1:0] rd_port;
	wire [31:0] port_read;
	reg [7:0] rd_byte;

	// Maps an address onto its register group; misaligned or unknown is none.
	function [2:0] reg_group;
		input [11:0] addr;
		begin
			if (addr[1:0] != 2'h0) begin
				reg_group = `GRP_NONE;
			end else begin
				// Widened so the selector matches the shifted offsets bit for bit.
				case ({4'h0, addr[11:4]})
					`OFS_DATA >> 4: reg_group = `GRP_DATA;
					`OFS_DIR >> 4: reg_group = `GRP_DIR;
					`OFS_PULL >> 4: reg_group = `GRP_PULL;
					`OFS_SLEW >> 4: reg_group = `GRP_SLEW;
					`OFS_DRIVE >> 4: reg_group = `GRP_DRIVE;
					default: reg_group = `GRP_NONE;
				endcase
			end
		end
	endfunction

	// Handshakes: one write and one read in flight, each holds until answered.
	assign AWREADY_O = ~aw_full_reg & ~bvalid_reg;
	assign WREADY_O = ~w_full_reg & ~bvalid_reg;
	assign ARREADY_O = ~rvalid_reg;
	assign aw_take = AWVALID_I & AWREADY_O;
	assign w_take = WVALID_I & WREADY_O;
	assign ar_take = ARVALID_I & ARREADY_O;
	assign do_write = aw_full_reg & w_full_reg & ~bvalid_reg;

	assign BVALID_O = bvalid_reg;
	assign BRESP_O = bresp_reg;
	assign RVALID_O = rvalid_reg;
	assign RDATA_O = rdata_reg;
	assign RRESP_O = rresp_reg;

	assign wr_grp = reg_group(aw_addr_reg);
	assign wr_port = aw_addr_reg[3:2];
	assign rd_grp = reg_group(ARADDR_I);
	assign rd_port = ARADDR_I[3:2];

	// Address and data are captured independently so either may arrive first.
	always @(posedge SYS_CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			aw_full_reg <= 1'b0;
			aw_addr_reg <= 12'h000;
			w_full_reg <= 1'b0;
			w_data_reg <= 8'h00;
			w_strb_reg <= 1'b0;
		end else begin
			if (aw_take) begin
				aw_full_reg <= 1'b1;
				aw_addr_reg <= AWADDR_I;
			end else if (do_write) begin
				aw_full_reg <= 1'b0;
			end
			if (w_take) begin
				w_full_reg <= 1'b1;
				w_data_reg <= WDATA_I[7:0];
				w_strb_reg <= WSTRB_I[0];
			end else if (do_write) begin
				w_full_reg <= 1'b0;
			end
		end
	end

	// Write response; the unmapped address gets a slave error.
	always @(posedge SYS_CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			bvalid_reg <= 1'b0;
			bresp_reg <= `RESP_OKAY;
		end else begin
			if (do_write) begin
				bvalid_reg <= 1'b1;
				bresp_reg <= (wr_grp == `GRP_NONE) ? `RESP_SLVERR : `RESP_OKAY;
			end else if (BREADY_I) begin
				bvalid_reg <= 1'b0;
			end
		end
	end

	// Register writes; only the low byte lane carries a port, so only its strobe counts.
	always @(posedge SYS_CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			data_reg <= {4{`RST_DATA}};
			dir_reg <= {4{`RST_DIR}};
			pull_reg <= {4{`RST_PULL}};
			slew_reg <= {4{`RST_SLEW}};
			drive_reg <= {4{`RST_DRIVE}};
		end else if (do_write && w_strb_reg) begin
			case (wr_grp)
				`GRP_DATA: begin
					// Latched whatever the direction, so data may be set up first.
					data_reg[{wr_port, 3'h0} +: 8] <= w_data_reg;
				end
				`GRP_DIR: begin
					dir_reg[{wr_port, 3'h0} +: 8] <= w_data_reg;
				end
				`GRP_PULL: begin
					pull_reg[{wr_port, 3'h0} +: 8] <= w_data_reg;
				end
				`GRP_SLEW: begin
					slew_reg[{wr_port, 3'h0} +: 8] <= w_data_reg;
				end
				`GRP_DRIVE: begin
					drive_reg[{wr_port, 3'h0} +: 8] <= w_data_reg;
				end
				default: begin
					data_reg <= data_reg;
				end
			endcase
		end
	end

	// Read mux; data reads show port_read (latch where the direction bit is set, else pin state; analog bits zero), the others the stored byte.
	always @* begin
		rd_byte = 8'h00;
		case (rd_grp)
			`GRP_DATA: begin
				rd_byte = port_read[{rd_port, 3'h0} +: 8];
			end
			`GRP_DIR: begin
				rd_byte = dir_reg[{rd_port, 3'h0} +: 8];
			end
			`GRP_PULL: begin
				rd_byte = pull_reg[{rd_port, 3'h0} +: 8];
			end
			`GRP_SLEW: begin
				rd_byte = slew_reg[{rd_port, 3'h0} +: 8];
			end
			`GRP_DRIVE: begin
				rd_byte = drive_reg[{rd_port, 3'h0} +: 8];
			end
			default: begin
				rd_byte = 8'h00;
			end
		endcase
	end

	// Read answer one edge after the address is taken; upper bits read zero.
	always @(posedge SYS_CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			rvalid_reg <= 1'b0;
			rdata_reg <= 32'h00000000;
			rresp_reg <= `RESP_OKAY;
		end else begin
			if (ar_take) begin
				rvalid_reg <= 1'b1;
				rdata_reg <= {24'h000000, rd_byte};
				rresp_reg <= (rd_grp == `GRP_NONE) ? `RESP_SLVERR : `RESP_OKAY;
			end else if (RREADY_I) begin
				rvalid_reg <= 1'b0;
			end
		end
	end

	// One pin slice per port; only port G carries the oscillator pins.
	genvar g;
	generate
		for (g = 0; g < 4; g = g + 1) begin : port_slice
			port_pins #(
				.OSC_PORT((g == `PORT_G_IDX + 1) ? 1'b1 : 1'b0)
			) u_pins (
				.clk_i(SYS_CLK_I),
				.arst_n_i(ARST_N_I),
				.pin_i(PIN_I[g * 8 +: 8]),
				.out_o(PIN_O[g * 8 +: 8]),
				.oe_n_o(PIN_OE_N_O[g * 8 +: 8]),
				.pull_o(PIN_PULLUP_O[g * 8 +: 8]),
				.slew_o(PIN_SLEW_O[g * 8 +: 8]),
				.hidrive_o(PIN_HIDRIVE_O[g * 8 +: 8]),
				.latch_i(data_reg[g * 8 +: 8]),
				.dir_i(dir_reg[g * 8 +: 8]),
				.pull_en_i(pull_reg[g * 8 +: 8]),
				.slew_en_i(slew_reg[g * 8 +: 8]),
				.drive_en_i(drive_reg[g * 8 +: 8]),
				.per_en_i(PERIPH_EN_I[g * 8 +: 8]),
				.per_dir_i(PERIPH_DIR_I[g * 8 +: 8]),
				.per_out_i(PERIPH_OUT_I[g * 8 +: 8]),
				.ana_en_i(ANALOG_EN_I[g * 8 +: 8]),
				.kbd_en_i(KEYPAD_EN_I[g * 8 +: 8]),
				.osc_en_i(OSC_EN_I),
				.read_o(port_read[g * 8 +: 8]),
				.sync_o(PIN_SYNC_O[g * 8 +: 8])
			);
		end
	endgenerate

endmodule

/* File: hdl/port_pins.v */
`timescale 1ns/100ps
`include "gpio_map.vh"

module port_pins #(
	parameter [0:0] OSC_PORT = 1'b0
) (
	// Clock and reset.
	input wire clk_i,
	input wire arst_n_i,
	// Pad side.
	input wire [7:0] pin_i,
	output reg [7:0] out_o,
	output reg [7:0] oe_n_o,
	output reg [7:0] pull_o,
	output reg [7:0] slew_o,
	output reg [7:0] hidrive_o,
	// Port registers.
	input wire [7:0] latch_i,
	input wire [7:0] dir_i,
	input wire [7:0] pull_en_i,
	input wire [7:0] slew_en_i,
	input wire [7:0] drive_en_i,
	// Peripheral overrides.
	input wire [7:0] per_en_i,
	input wire [7:0] per_dir_i,
	input wire [7:0] per_out_i,
	input wire [7:0] ana_en_i,
	input wire [7:0] kbd_en_i,
	input wire osc_en_i,
	// Results.
	output wire [7:0] read_o,
	output wire [7:0] sync_o
);

	reg [7:0] meta_reg;
	reg [7:0] sync_reg;
	wire [7:0] osc_bits;
	wire [7:0] ana;
	wire [7:0] drive;
	wire [7:0] value;

	// Oscillator pins behave like analog pins: no port setting reaches them.
	assign osc_bits = (OSC_PORT && osc_en_i) ? `OSC_MASK : 8'h00;
	assign ana = ana_en_i | osc_bits;

	// Keypad forces input, a peripheral owns direction, else the port bit.
	assign drive = ~ana & ~kbd_en_i & ((per_en_i & per_dir_i) | (~per_en_i & dir_i));
	assign value = (per_en_i & per_dir_i & per_out_i) | (~(per_en_i & per_dir_i) & latch_i);

	// Read-back follows the port direction bit only; analog bits read zero.
	assign read_o = ~ana & ((dir_i & latch_i) | (~dir_i & sync_reg));
	assign sync_o = ~ana & sync_reg;

	// Two-stage synchroniser; only the second stage is looked at.
	always @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			meta_reg <= 8'h00;
			sync_reg <= 8'h00;
		end else begin
			meta_reg <= pin_i;
			sync_reg <= meta_reg;
		end
	end

	// Pad controls are registered so the pads never see decode glitches.
	always @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			out_o <= 8'h00;
			oe_n_o <= 8'hFF;
			pull_o <= 8'h00;
			slew_o <= 8'h00;
			hidrive_o <= 8'h00;
		end else begin
			out_o <= value & drive;
			oe_n_o <= ~drive;
			pull_o <= pull_en_i & ~drive & ~ana;
			slew_o <= slew_en_i & drive;
			hidrive_o <= drive_en_i & drive;
		end
	end

endmodule

/* File: tb/gpio_ports_sva.sv */
`timescale 1ns/100ps
module gpio_ports_sva (
	// Clock, reset and read handshake.
	input wire SYS_CLK_I,
	input wire ARST_N_I,
	input wire ARVALID_I,
	input wire ARREADY_O,
	input wire RVALID_O,
	// Pads and overrides.
	input wire [31:0] PIN_O,
	input wire [31:0] PIN_OE_N_O,
	input wire [31:0] PIN_PULLUP_O,
	input wire [31:0] PIN_SLEW_O,
	input wire [31:0] PERIPH_EN_I,
	input wire [31:0] PERIPH_DIR_I,
	input wire [31:0] PERIPH_OUT_I,
	input wire [31:0] KEYPAD_EN_I,
	input wire [31:0] ANALOG_EN_I,
	input wire OSC_EN_I
);
	// Pins a peripheral should drive next edge; cleared in reset so the first check is quiet.
	reg [31:0] own_reg;
	always @(posedge SYS_CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I)
			own_reg <= 32'h0;
		else
			own_reg <= PERIPH_EN_I & PERIPH_DIR_I & ~ANALOG_EN_I & ~KEYPAD_EN_I
				& ~{1'h0, {2{OSC_EN_I}}, 29'h0};
	end

	default clocking @(posedge SYS_CLK_I); endclocking
	default disable iff (!ARST_N_I);

	// Pad outputs follow their causes one edge later.
	a_analog_no_drive: assert property (~|($past(ANALOG_EN_I) & ~PIN_OE_N_O))
		else $error("analog pin driven");
	a_keypad_input: assert property (~|($past(KEYPAD_EN_I) & ~PIN_OE_N_O))
		else $error("keypad pin driven");
	a_osc_pins_free: assert property ($past(OSC_EN_I) |->
		PIN_OE_N_O[30:29] == 2'h3 && PIN_PULLUP_O[30:29] == 2'h0)
		else $error("oscillator pin touched");
	a_pull_analog_off: assert property (~|($past(ANALOG_EN_I) & PIN_PULLUP_O))
		else $error("pullup on analog pin");
	a_pull_output_off: assert property (~|(PIN_PULLUP_O & ~PIN_OE_N_O))
		else $error("pullup on output pin");
	a_slew_input_off: assert property (~|(PIN_SLEW_O & PIN_OE_N_O))
		else $error("slew on input pin");
	a_periph_value: assert property (~|(own_reg & (PIN_OE_N_O | (PIN_O ^ $past(PERIPH_OUT_I)))))
		else $error("peripheral value not driven");
	a_read_answer: assert property (ARVALID_I && ARREADY_O |=> RVALID_O)
		else $error("read not answered");
endmodule

bind gpio_ports gpio_ports_sva i_gpio_ports_sva (.SYS_CLK_I, .ARST_N_I, .ARVALID_I,
	.ARREADY_O, .RVALID_O, .PIN_O, .PIN_OE_N_O, .PIN_PULLUP_O, .PIN_SLEW_O, .PERIPH_EN_I,
	.PERIPH_DIR_I, .PERIPH_OUT_I, .KEYPAD_EN_I, .ANALOG_EN_I, .OSC_EN_I);

/* File: tb/pad_model.sv */
`timescale 1ns/100ps
module pad_model (
	// Clock and device pad outputs.
	input wire clk_i,
	input wire [31:0] out_i,
	input wire [31:0] oe_n_i,
	input wire [31:0] pull_i,
	// Board drive.
	input wire [31:0] ext_val_i,
	input wire [31:0] ext_en_i,
	// Resolved pad level.
	output wire [31:0] pin_o
);
	// An undriven pin without pullup wanders, so it flips every cycle.
	reg [31:0] float_reg = 32'h0;
	always @(posedge clk_i) float_reg <= ~float_reg;
	// Device driver wins, then the board, then the pullup.
	assign pin_o = (~oe_n_i & out_i) | (oe_n_i & ext_en_i & ext_val_i)
		| (oe_n_i & ~ext_en_i & (pull_i | float_reg));
endmodule

/* File: tb/tb_gpio_ports.sv */
`timescale 1ns/100ps
module tb_gpio_ports;
	logic SYS_CLK_I, ARST_N_I, AWVALID_I, WVALID_I, BREADY_I, ARVALID_I, RREADY_I, OSC_EN_I;
	logic [11:0] AWADDR_I, ARADDR_I;
	logic [3:0] WSTRB_I;
	logic [31:0] WDATA_I, PERIPH_EN_I, PERIPH_DIR_I, PERIPH_OUT_I, KEYPAD_EN_I, ANALOG_EN_I;
	logic [31:0] ext_val, ext_en;
	wire AWREADY_O, WREADY_O, BVALID_O, ARREADY_O, RVALID_O;
	wire [1:0] BRESP_O, RRESP_O;
	wire [31:0] RDATA_O, PIN_I, PIN_O, PIN_OE_N_O, PIN_PULLUP_O, PIN_SLEW_O, PIN_HIDRIVE_O;
	wire [31:0] PIN_SYNC_O;
	int err_count = 0;
	int n_tests = 0;
	int cyc = 0;

	gpio_ports i_gpio_ports (.SYS_CLK_I, .ARST_N_I, .AWADDR_I, .AWVALID_I, .AWREADY_O,
		.WDATA_I, .WSTRB_I, .WVALID_I, .WREADY_O, .BRESP_O, .BVALID_O, .BREADY_I, .ARADDR_I,
		.ARVALID_I, .ARREADY_O, .RDATA_O, .RRESP_O, .RVALID_O, .RREADY_I, .PIN_I, .PIN_O,
		.PIN_OE_N_O, .PIN_PULLUP_O, .PIN_SLEW_O, .PIN_HIDRIVE_O, .PERIPH_EN_I, .PERIPH_DIR_I,
		.PERIPH_OUT_I, .KEYPAD_EN_I, .PIN_SYNC_O, .ANALOG_EN_I, .OSC_EN_I);
	pad_model i_pad_model (.clk_i(SYS_CLK_I), .out_i(PIN_O), .oe_n_i(PIN_OE_N_O),
		.pull_i(PIN_PULLUP_O), .ext_val_i(ext_val), .ext_en_i(ext_en), .pin_o(PIN_I));

	// Clock and a watchdog that ends a hung run.
	always #2.5 SYS_CLK_I = ~SYS_CLK_I;
	always @(posedge SYS_CLK_I) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_count++;
			report_and_stop;
		end
	end

	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		n_tests++;
		if (g !== e) begin
			err_count++;
			$display("wrong value at %0t: got %h, expected %h", $time, g, e);
		end
	endtask

	// Address and data go out together; each is released once its ready is seen.
	task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
		@(posedge SYS_CLK_I);
		AWADDR_I <= a;
		WDATA_I <= {24'h0, d};
		AWVALID_I <= 1'h1;
		WVALID_I <= 1'h1;
		BREADY_I <= 1'h1;
		do begin
			@(posedge SYS_CLK_I);
			if (AWREADY_O) AWVALID_I <= 1'h0;
			if (WREADY_O) WVALID_I <= 1'h0;
		end while (BVALID_O !== 1'h1);
		BREADY_I <= 1'h0;
		chk({6'h0, BRESP_O}, {6'h0, er});
	endtask

	task automatic rd(input logic [11:0] a, input logic [7:0] e, input logic [1:0] er);
		@(posedge SYS_CLK_I);
		ARADDR_I <= a;
		ARVALID_I <= 1'h1;
		RREADY_I <= 1'h1;
		do begin
			@(posedge SYS_CLK_I);
			if (ARREADY_O) ARVALID_I <= 1'h0;
		end while (RVALID_O !== 1'h1);
		RREADY_I <= 1'h0;
		chk(RDATA_O[7:0], e);
		chk({6'h0, RRESP_O}, {6'h0, er});
	endtask

	// Covers the one-edge pad update and the two-stage pin synchroniser.
	task automatic st;
		repeat (3) @(posedge SYS_CLK_I);
	endtask

	task automatic done(input string s);
		$display("test %s finished", s);
	endtask

	initial begin
		logic [11:0] a;
		{SYS_CLK_I, ARST_N_I, AWVALID_I, WVALID_I, BREADY_I, ARVALID_I, RREADY_I} = 7'h0;
		{OSC_EN_I, AWADDR_I, ARADDR_I, WDATA_I, PERIPH_EN_I, PERIPH_DIR_I} = 121'h0;
		{PERIPH_OUT_I, KEYPAD_EN_I, ANALOG_EN_I, ext_val} = 128'h0;
		WSTRB_I = 4'hF;
		ext_en = 32'hFFFFFFF0;
		repeat (8) @(posedge SYS_CLK_I);
		ARST_N_I <= 1'h1;
		@(posedge SYS_CLK_I);
		// Reset values of every port.
		for (a = 12'h0; a < 12'h10; a = a + 12'h4) begin
			rd(12'h010 + a, 8'h00, 2'h0);
			rd(12'h100 + a, 8'h00, 2'h0);
			rd(12'h110 + a, 8'hFF, 2'h0);
			rd(12'h120 + a, 8'h00, 2'h0);
		end
		chk(PIN_OE_N_O[7:0], 8'hFF);
		done("reset");
		// Port E latches while input, then drives after the direction write.
		ext_val[15:8] <= 8'h5A;
		wr(12'h004, 8'hC3, 2'h0);
		st;
		chk(PIN_SYNC_O[15:8], 8'h5A);
		rd(12'h004, 8'h5A, 2'h0);
		wr(12'h014, 8'hFF, 2'h0);
		wr(12'h104, 8'hFF, 2'h0);
		wr(12'h124, 8'h0F, 2'h0);
		st;
		rd(12'h004, 8'hC3, 2'h0);
		chk(PIN_O[15:8], 8'hC3);
		chk(PIN_OE_N_O[15:8], 8'h00);
		chk(PIN_PULLUP_O[15:8], 8'h00);
		chk(PIN_SLEW_O[15:8], 8'hFF);
		chk(PIN_HIDRIVE_O[15:8], 8'h0F);
		done("port E");
		// Port D pullups hold undriven inputs high.
		wr(12'h100, 8'h0F, 2'h0);
		st;
		chk(PIN_PULLUP_O[7:0], 8'h0F);
		chk(PIN_SLEW_O[7:0], 8'h00);
		rd(12'h000, 8'h0F, 2'h0);
		done("port D");
		// Port F under peripheral, then analog, control.
		wr(12'h008, 8'hFF, 2'h0);
		wr(12'h018, 8'hFF, 2'h0);
		wr(12'h108, 8'hFF, 2'h0);
		PERIPH_EN_I[23:16] <= 8'hFF;
		PERIPH_DIR_I[23:16] <= 8'h0F;
		PERIPH_OUT_I[23:16] <= 8'hA5;
		st;
		chk(PIN_OE_N_O[23:16], 8'hF0);
		chk(PIN_O[23:16], 8'h05);
		rd(12'h008, 8'hFF, 2'h0);
		ANALOG_EN_I[23:16] <= 8'h03;
		st;
		chk(PIN_OE_N_O[23:16], 8'hF3);
		chk(PIN_PULLUP_O[23:16], 8'hF0);
		rd(12'h008, 8'hFC, 2'h0);
		done("port F");
		// Port G keypad input and oscillator pins.
		wr(12'h00C, 8'hFF, 2'h0);
		wr(12'h01C, 8'hFF, 2'h0);
		KEYPAD_EN_I[24] <= 1'h1;
		OSC_EN_I <= 1'h1;
		st;
		chk(PIN_OE_N_O[31:24], 8'h61);
		chk({6'h0, PIN_SYNC_O[30:29]}, 8'h00);
		rd(12'h00C, 8'h9F, 2'h0);
		done("port G");
		// Addresses outside the map.
		wr(12'h200, 8'hFF, 2'h2);
		rd(12'h200, 8'h00, 2'h2);
		done("unmapped");
		report_and_stop;
	end
endmodule
